/* File: bpq_host_model.sv */
// Host controller model that reads and writes the query table
`timescale 1ns/1ps
`default_nettype none
module bpq_host_model
(
	// Clock
	input  wire logic        clock,
	// Table port and the burst code the host keeps
	output var logic [8:0]   addr = 9'h000,
	output var logic [15:0]  wrData = 16'h0000,
	output var logic         wrStrobe = 1'b0,
	output var logic         rdStrobe = 1'b0,
	input  wire logic [15:0] rdData,
	output var logic [2:0]   burstCfg_reg = 3'h0
);
	// One strobe cycle; read data are taken only in the cycle after it
	task automatic op(input logic [8:0] a, input logic [15:0] v, input logic w, output logic [15:0] d);
		@(posedge clock);
		{addr, wrData} <= {a, v};
		{wrStrobe, rdStrobe} <= {w, !w};
		@(posedge clock);
		{wrStrobe, rdStrobe} <= 2'b00;
		@(negedge clock);
		d = rdData;
		if (!w && a >= 9'h129 && a <= 9'h12c)
			burstCfg_reg = d[2:0];
	endtask
endmodule // bpq_host_model
`default_nettype wire

/* File: bpq_query_table.sv */
// Read-only burst and partition query table behind a plain register port
//
// Functional notes
// - Location 128 reports four capability entries follow
// - Entry low three bits code burst length
// - Code seven means continuous linear bursting
// - First capability entry reads code one
// - Second capability entry reads code two
// - Third capability entry reads code three
// - Fourth capability entry reads code seven
// - Partition region count; zero means single
// - Two-byte region description size, self-inclusive
// - Two-byte identical partition count
// - Per-partition program/erase limits by nibble
// - Other-partition limits while this one programs
// - Other-partition limits while this one erases
// - Erase region count; zero means bulk erase
// - Partition size equals sum count times size
// - Geometry low half y, y+1 blocks
// - Geometry high half z, z*256 bytes
`timescale 1ns/1ps
`default_nettype none
`include "bpq_table_map.svh"

module bpq_query_table
(
	// Clock and reset
	input  wire logic                    clock,
	input  wire logic                    srst,
	// Register port
	input  wire logic [`BPQ_ADDR_W-1:0]  addr,
	input  wire logic [`BPQ_DATA_W-1:0]  wrData,
	input  wire logic                    wrStrobe,
	input  wire logic                    rdStrobe,
	output logic      [`BPQ_DATA_W-1:0]  rdData
);

	// Erase block geometry field, count in the low half and size in the high half
	localparam logic [31:0] GEOMETRY = {`BPQ_VAL_BLOCK_SIZE_Z, `BPQ_VAL_BLOCK_COUNT_M1};

	// Two-location fields and the control reset value, held as sized constants so they can be sliced
	localparam logic [15:0] REGION_SIZE = `BPQ_VAL_REGION_SIZE;
	localparam logic [15:0] IDENT_PART  = `BPQ_VAL_IDENT_PART;
	localparam logic [7:0]  RST_CONTROL = `BPQ_RST_CONTROL;

	// Partition size from the single erase block type: (y+1) * z * 256 bytes
	localparam logic [31:0] PART_BYTES =
		(({16'h0000, `BPQ_VAL_BLOCK_COUNT_M1} + 32'h0000_0001) * {16'h0000, `BPQ_VAL_BLOCK_SIZE_Z})
		<< `BPQ_BLOCK_UNIT_SHIFT;

	bpq_table_pkg::bpq_state_t stateReg;
	bpq_table_pkg::bpq_state_t stateNext;

	// Constant table contents by location; unmapped locations give zero
	function automatic logic [7:0] tableByte(input logic [`BPQ_ADDR_W-1:0] a);
		logic [7:0] b;
		b = 8'h00;
		case (a)
			`BPQ_OFF_SYNC_FIELD_NUM:  b = `BPQ_VAL_SYNC_FIELD_NUM;
			`BPQ_OFF_BURST_CAP_ONE:   b = `BPQ_VAL_BURST_CAP_ONE;
			`BPQ_OFF_BURST_CAP_TWO:   b = `BPQ_VAL_BURST_CAP_TWO;
			`BPQ_OFF_BURST_CAP_THREE: b = `BPQ_VAL_BURST_CAP_THREE;
			`BPQ_OFF_BURST_CAP_FOUR:  b = `BPQ_VAL_BURST_CAP_FOUR;
			`BPQ_OFF_PART_REGIONS:    b = `BPQ_VAL_PART_REGIONS;
			`BPQ_OFF_REGION_SIZE_LO:  b = REGION_SIZE[7:0];
			`BPQ_OFF_REGION_SIZE_HI:  b = REGION_SIZE[15:8];
			`BPQ_OFF_IDENT_PART_LO:   b = IDENT_PART[7:0];
			`BPQ_OFF_IDENT_PART_HI:   b = IDENT_PART[15:8];
			`BPQ_OFF_LOCAL_LIMITS:    b = `BPQ_VAL_LOCAL_LIMITS;
			`BPQ_OFF_DURING_PROGRAM:  b = `BPQ_VAL_DURING_PROGRAM;
			`BPQ_OFF_DURING_ERASE:    b = `BPQ_VAL_DURING_ERASE;
			`BPQ_OFF_ERASE_REGIONS:   b = `BPQ_VAL_ERASE_REGIONS;
			`BPQ_OFF_GEOMETRY_B0:     b = GEOMETRY[7:0];
			`BPQ_OFF_GEOMETRY_B1:     b = GEOMETRY[15:8];
			`BPQ_OFF_GEOMETRY_B2:     b = GEOMETRY[23:16];
			`BPQ_OFF_GEOMETRY_B3:     b = GEOMETRY[31:24];
			default:                  b = 8'h00;
		endcase
		return b;
	endfunction

	// True for a location that belongs to the constant table
	function automatic logic isTableAddr(input logic [`BPQ_ADDR_W-1:0] a);
		return (a >= `BPQ_OFF_SYNC_FIELD_NUM) && (a <= `BPQ_OFF_GEOMETRY_B3);
	endfunction

	// Local control, status and derived partition size locations
	function automatic logic [7:0] localByte(
		input logic [`BPQ_ADDR_W-1:0] a,
		input bpq_table_pkg::bpq_state_t s
	);
		logic [7:0] b;
		b = 8'h00;
		case (a)
			`BPQ_OFF_CONTROL:       b = {7'h00, s.tableEnable};
			`BPQ_OFF_STATUS:        b = {7'h00, s.writeRejected};
			`BPQ_OFF_PART_BYTES_B0: b = PART_BYTES[7:0];
			`BPQ_OFF_PART_BYTES_B1: b = PART_BYTES[15:8];
			`BPQ_OFF_PART_BYTES_B2: b = PART_BYTES[23:16];
			`BPQ_OFF_PART_BYTES_B3: b = PART_BYTES[31:24];
			default:                b = 8'h00;
		endcase
		return b;
	endfunction

	// Next state: read data for one cycle only, control write, sticky reject flag
	always_comb
	begin
		stateNext = stateReg;
		stateNext.rdData = `BPQ_RST_READ_DATA;
		if (rdStrobe)
		begin
			if (isTableAddr(addr))
			begin
				// Byte on low lines, upper lines zero; disabled table reads zero
				stateNext.rdData = stateReg.tableEnable ? {8'h00, tableByte(addr)} : 16'h0000;
			end
			else
			begin
				stateNext.rdData = {8'h00, localByte(addr, stateReg)};
			end
		end
		if (wrStrobe)
		begin
			if (addr == `BPQ_OFF_CONTROL)
			begin
				stateNext.tableEnable = wrData[`BPQ_CTRL_ENABLE_BIT];
			end
			// Writing one clears the flag
			if ((addr == `BPQ_OFF_STATUS) && wrData[`BPQ_STAT_REJECT_BIT])
			begin
				stateNext.writeRejected = 1'b0;
			end
			// Table writes are dropped and only noted; set wins over clear
			if (isTableAddr(addr))
			begin
				stateNext.writeRejected = 1'b1;
			end
		end
	end

	// State register
	always_ff @(posedge clock)
	begin
		if (srst)
		begin
			stateReg.rdData        <= `BPQ_RST_READ_DATA;
			stateReg.tableEnable   <= RST_CONTROL[`BPQ_CTRL_ENABLE_BIT];
			stateReg.writeRejected <= 1'b0;
		end
		else
		begin
			stateReg <= stateNext;
		end
	end

	// Outputs straight from the state flops
	assign rdData = stateReg.rdData;

endmodule // bpq_query_table
`default_nettype wire

/* File: bpq_query_table_props.sv */
// Assertion checker for the burst and partition query table
`timescale 1ns/1ps
`default_nettype none
module bpq_query_table_chk
(
	// Clock and reset
	input wire logic        clock,
	input wire logic        srst,
	// Register port
	input wire logic [8:0]  addr,
	input wire logic [15:0] wrData,
	input wire logic        wrStrobe,
	input wire logic        rdStrobe,
	input wire logic [15:0] rdData
);
	logic tabOn_reg;
	// Mirror of the table enable, so reads of a disabled table are not judged
	always_ff @(posedge clock)
		tabOn_reg <= srst ? 1'b1 : (wrStrobe && addr == 9'h1f0) ? wrData[0] : tabOn_reg;
	default clocking cb @(posedge clock); endclocking
	default disable iff (srst);
	sequence readOf(logic [8:0] a); rdStrobe && addr == a && tabOn_reg; endsequence
	property tabVal(logic [8:0] a, logic [15:0] v); readOf(a) |=> rdData == v; endproperty
	AST_IDLE_ZERO: assert property (!rdStrobe |=> rdData == 16'h0) else $error("data outside read");
	AST_HIGH_ZERO: assert property (rdData[15:8] == 8'h0) else $error("upper byte set");
	AST_FIELD_NUM: assert property (tabVal(9'h128, 16'h4)) else $error("field count");
	AST_CAP_ONE: assert property (tabVal(9'h129, 16'h1)) else $error("cap one");
	AST_CAP_TWO: assert property (tabVal(9'h12a, 16'h2)) else $error("cap two");
	AST_CAP_THREE: assert property (tabVal(9'h12b, 16'h3)) else $error("cap three");
	AST_CAP_FOUR: assert property (tabVal(9'h12c, 16'h7)) else $error("cap four");
	AST_BLK_SIZE: assert property (tabVal(9'h139, 16'h2)) else $error("block size");
	AST_PART_REGIONS: assert property (tabVal(9'h12d, 16'h1)) else $error("partition regions");
	AST_LOCAL_LIMITS: assert property (tabVal(9'h132, 16'h11)) else $error("local limits");
	AST_ERASE_REGIONS: assert property (tabVal(9'h135, 16'h1)) else $error("erase regions");
	AST_BLK_COUNT: assert property (tabVal(9'h136, 16'h3f)) else $error("block count");
endmodule // bpq_query_table_chk
bind bpq_query_table bpq_query_table_chk u_chk (.clock(clock), .srst(srst), .addr(addr), .wrData(wrData),
	.wrStrobe(wrStrobe), .rdStrobe(rdStrobe), .rdData(rdData));
`default_nettype wire

/* File: bpq_table_map.svh */
// Offsets, field positions and constant contents of the burst and partition query table
`ifndef BPQ_TABLE_MAP_SVH
`define BPQ_TABLE_MAP_SVH

// Bus widths
`define BPQ_ADDR_W              9
`define BPQ_DATA_W              16

// Query locations
`define BPQ_OFF_SYNC_FIELD_NUM  9'h128
`define BPQ_OFF_BURST_CAP_ONE   9'h129
`define BPQ_OFF_BURST_CAP_TWO   9'h12a
`define BPQ_OFF_BURST_CAP_THREE 9'h12b
`define BPQ_OFF_BURST_CAP_FOUR  9'h12c
`define BPQ_OFF_PART_REGIONS    9'h12d
`define BPQ_OFF_REGION_SIZE_LO  9'h12e
`define BPQ_OFF_REGION_SIZE_HI  9'h12f
`define BPQ_OFF_IDENT_PART_LO   9'h130
`define BPQ_OFF_IDENT_PART_HI   9'h131
`define BPQ_OFF_LOCAL_LIMITS    9'h132
`define BPQ_OFF_DURING_PROGRAM  9'h133
`define BPQ_OFF_DURING_ERASE    9'h134
`define BPQ_OFF_ERASE_REGIONS   9'h135
`define BPQ_OFF_GEOMETRY_B0     9'h136
`define BPQ_OFF_GEOMETRY_B1     9'h137
`define BPQ_OFF_GEOMETRY_B2     9'h138
`define BPQ_OFF_GEOMETRY_B3     9'h139

// Local control, status and derived partition size locations
`define BPQ_OFF_CONTROL         9'h1f0
`define BPQ_OFF_STATUS          9'h1f1
`define BPQ_OFF_PART_BYTES_B0   9'h1f2
`define BPQ_OFF_PART_BYTES_B1   9'h1f3
`define BPQ_OFF_PART_BYTES_B2   9'h1f4
`define BPQ_OFF_PART_BYTES_B3   9'h1f5

// Field positions
`define BPQ_CAP_CODE_MSB        2
`define BPQ_NIB_PROG_MSB        3
`define BPQ_NIB_ERASE_LSB       4
`define BPQ_GEO_COUNT_MSB       15
`define BPQ_GEO_SIZE_LSB        16
`define BPQ_BLOCK_UNIT_SHIFT    8
`define BPQ_CTRL_ENABLE_BIT     0
`define BPQ_STAT_REJECT_BIT     0

// Table contents
`define BPQ_VAL_SYNC_FIELD_NUM  8'h04
`define BPQ_VAL_BURST_CAP_ONE   8'h01
`define BPQ_VAL_BURST_CAP_TWO   8'h02
`define BPQ_VAL_BURST_CAP_THREE 8'h03
`define BPQ_VAL_BURST_CAP_FOUR  8'h07
`define BPQ_VAL_PART_REGIONS    8'h01
`define BPQ_VAL_REGION_SIZE     16'h0018
`define BPQ_VAL_IDENT_PART      16'h0008
`define BPQ_VAL_LOCAL_LIMITS    8'h11
`define BPQ_VAL_DURING_PROGRAM  8'h01
`define BPQ_VAL_DURING_ERASE    8'h11
`define BPQ_VAL_ERASE_REGIONS   8'h01
`define BPQ_VAL_BLOCK_COUNT_M1  16'h003f
`define BPQ_VAL_BLOCK_SIZE_Z    16'h0200
`define BPQ_CODE_CONTINUOUS     3'h7

// Reset values
`define BPQ_RST_CONTROL         8'h01
`define BPQ_RST_READ_DATA       16'h0000

`endif

/* File: bpq_table_pkg.sv */
// Types shared by the burst and partition query table
package bpq_table_pkg;

	// Register state of the table front end
	typedef struct packed {
		logic [15:0] rdData;
		logic        tableEnable;
		logic        writeRejected;
	} bpq_state_t;

endpackage

/* File: burst_partition_query_table_test.sv */
// Testbench for the burst and partition query table
`timescale 1ns/1ps
`default_nettype none
module burst_partition_query_table_test;
	logic        clock = 1'b0;
	logic        srst = 1'b1;
	logic [8:0]  addr;
	logic [15:0] wrData, rdData, seen;
	logic        wrStrobe, rdStrobe;
	int          failures = 0, checksDone = 0;
	// Location in the upper half, expected read data in the lower half
	logic [31:0] rows [23] = '{
		32'h01280004, 32'h01290001, 32'h012a0002, 32'h012b0003, 32'h012c0007,
		32'h012d0001, 32'h012e0018, 32'h012f0000, 32'h01300008, 32'h01310000,
		32'h01320011, 32'h01330001, 32'h01340011, 32'h01350001, 32'h0136003f,
		32'h01370000, 32'h01380000, 32'h01390002, 32'h01f20000, 32'h01f30000,
		32'h01f40080, 32'h01f50000, 32'h01000000};
	// Clock of 100 ns period
	always #50 clock = ~clock;
	bpq_query_table u_dut (.clock(clock), .srst(srst), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData));
	bpq_host_model u_host (.clock(clock), .addr(addr), .wrData(wrData), .wrStrobe(wrStrobe),
		.rdStrobe(rdStrobe), .rdData(rdData), .burstCfg_reg());
	// Compare, read and report helpers
	task automatic check(input logic [8:0] loc, input logic [15:0] got, input logic [15:0] exp);
		checksDone++;
		failures += int'(got !== exp);
		if (got !== exp)
			$display("[ERR] loc %h expected %h seen %h", loc, exp, got);
	endtask
	task automatic rc(input logic [8:0] a, input logic [15:0] e);
		u_host.op(a, 16'h0000, 1'b0, seen);
		check(a, seen, e);
	endtask
	task automatic wrap_up();
		$display("checks %0d mismatches %0d", checksDone, failures);
		if (failures == 0 && checksDone > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	// Reset, table sweep, refused table write, disabled table
	initial
	begin
		repeat (3) @(posedge clock);
		srst <= 1'b0;
		rc(9'h1f0, 16'h0001);
		foreach (rows[i])
			rc(rows[i][24:16], rows[i][15:0]);
		check(9'h12c, {13'h0000, u_host.burstCfg_reg}, 16'h0007);
		u_host.op(9'h129, 16'h00fe, 1'b1, seen);
		rc(9'h129, 16'h0001);
		rc(9'h1f1, 16'h0001);
		u_host.op(9'h1f0, 16'h0000, 1'b1, seen);
		rc(9'h12c, 16'h0000);
		wrap_up();
	end
endmodule // burst_partition_query_table_test
`default_nettype wire
